// ---- hw/pwsd_cfg.svh ----
/*
 * constants for the pwm shutdown and dead-band block: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz system clock and a 32-bit avalon-mm register bus.
 */
`ifndef PWSD_CFG_SVH
`define PWSD_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PWSD_OFS_SHUTDOWN   4'h0
`define PWSD_OFS_PWMCTRL    4'h4
`define PWSD_OFS_IRQSTAT    4'h8
`define PWSD_OFS_IRQEN      4'hc
`define PWSD_OFS_IRQCLR     4'h0
`define PWSD_OFS_IRQCLR_HI  1'b1

// ----------------------------------------------------------------------
// shutdown control fields
// ----------------------------------------------------------------------
`define PWSD_EVT_BIT        7
`define PWSD_SRC_HI         6
`define PWSD_SRC_LO         4
`define PWSD_SSA_HI         3
`define PWSD_SSA_LO         2
`define PWSD_SSB_HI         1
`define PWSD_SSB_LO         0
`define PWSD_SHUTDOWN_RST   8'h00

// ----------------------------------------------------------------------
// enhanced pwm control fields
// ----------------------------------------------------------------------
`define PWSD_RESTART_BIT    7
`define PWSD_DELAY_HI       6
`define PWSD_PWMCTRL_RST    8'h00

// ----------------------------------------------------------------------
// timing: one delay step is four oscillator periods
// ----------------------------------------------------------------------
`define PWSD_TOSC_NS        10
`define PWSD_CLK_NS         10
`define PWSD_STEP_TOSC      4
`define PWSD_STEP_CYC       ((`PWSD_STEP_TOSC*`PWSD_TOSC_NS)/`PWSD_CLK_NS)

`endif

// ---- hw/pwsd_pkg.sv ----
/*
 * types shared by the pwm shutdown and dead-band block.
 * assumes nothing beyond a systemverilog compiler.
 */
package pwsd_pkg;

  // ----------------------------------------------------------------------
  // pin drive for one output
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
  } pwsd_pin_s;

  // ----------------------------------------------------------------------
  // avalon-mm request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } pwsd_avreq_s;

  typedef enum logic [1:0] {
    PWSD_IDLE,
    PWSD_ANSWER
  } pwsd_bus_e;

endpackage : pwsd_pkg

// ---- hw/pwsd_deadband.sv ----
/*
 * dead-band delay for one pwm output: rising edges are delayed by a
 * programmable count of steps, falling edges pass at once.
 * assumes a one-cycle step enable from the parent.
 */
`timescale 1ns/10ps
`include "pwsd_cfg.svh"

module pwsd_deadband #(
  parameter int DW = 7
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // control
  input  wire logic          stepEn,
  input  wire logic [DW-1:0] delayCount,
  // data
  input  wire logic          rawIn,
  output      logic          delayedOut
);

  logic [DW-1:0] cnt_q;
  logic          prev_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q      <= '0;
      prev_q     <= 1'b0;
      delayedOut <= 1'b0;
    end else begin
      prev_q <= rawIn;
      if (!rawIn) begin
        delayedOut <= 1'b0;
        cnt_q      <= '0;
      end else if (!prev_q) begin
        cnt_q      <= delayCount;
        delayedOut <= (delayCount == '0);
      end else if (!delayedOut) begin
        if (cnt_q == '0) begin
          delayedOut <= 1'b1;
        end else if (stepEn) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule : pwsd_deadband

// ---- hw/pwsd_top.sv ----
/*
 * auto-shutdown, auto-restart and dead-band logic for a half-bridge pwm
 * pair, with an avalon-mm register slave and one level interrupt.
 * assumes the pwm timebase supplies raw a (b is taken as its inverse) and a period-start pulse,
 * and all inputs are synchronous to clk.
 */
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "pwsd_cfg.svh"

module pwsd_top #(
  parameter int DELAY_W = 7
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  output      logic [31:0] avsReaddata,
  output      logic        avsWaitrequest,
  // pwm timebase
  input  wire logic        pwmRawA,
  input  wire logic        pwmPeriodStart,
  // shutdown sources
  input  wire logic        eventPin_n,
  input  wire logic        comparatorOut,
  // output pins
  output      logic        pwmOutputA,
  output      logic        pwmOutputAOe,
  output      logic        pwmOutputB,
  output      logic        pwmOutputBOe,
  // interrupt
  output      logic        irq
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic       evtFlag_q;
  logic [2:0] srcSel_q;
  logic [1:0] stateA_q;
  logic [1:0] stateB_q;
  logic       autoRestart_q;
  logic [DELAY_W-1:0] delayCnt_q;
  logic       running_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqEn_q;
  logic [1:0] stepCnt_q;
  logic       stepEn;
  logic       condition;
  logic       wrShutdown;
  logic       wrCtrl;
  logic       wrEvt1;
  logic       evtRise;
  logic       evtFall;
  logic       dbA;
  logic       dbB;
  pwsd_pkg::pwsd_bus_e  busState_q;
  pwsd_pkg::pwsd_avreq_s req;

  assign req = '{address: avsAddress, read: avsRead, write: avsWrite,
                 writedata: avsWritedata};

  // ----------------------------------------------------------------------
  // shutdown condition
  // ----------------------------------------------------------------------
  // level sources
  assign condition = (srcSel_q[0] & comparatorOut) |
                     (srcSel_q[2] & ~eventPin_n);

  assign wrShutdown = busState_q == pwsd_pkg::PWSD_ANSWER && req.write &&
                      req.address == `PWSD_OFS_SHUTDOWN;
  assign wrCtrl     = busState_q == pwsd_pkg::PWSD_ANSWER && req.write &&
                      req.address == `PWSD_OFS_PWMCTRL;
  assign wrEvt1     = wrShutdown && req.writedata[`PWSD_EVT_BIT];

  // ----------------------------------------------------------------------
  // event flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evtFlag_q <= 1'b0;
    end else if (condition) begin
      evtFlag_q <= 1'b1;
    end else if (wrShutdown) begin
      evtFlag_q <= req.writedata[`PWSD_EVT_BIT];
    end else if (autoRestart_q) begin
      evtFlag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------------
  // field layout
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      srcSel_q <= 3'h0;
      stateA_q <= 2'h0;
      stateB_q <= 2'h0;
    end else if (wrShutdown) begin
      srcSel_q <= req.writedata[`PWSD_SRC_HI:`PWSD_SRC_LO];
      stateA_q <= req.writedata[`PWSD_SSA_HI:`PWSD_SSA_LO];
      stateB_q <= req.writedata[`PWSD_SSB_HI:`PWSD_SSB_LO];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      autoRestart_q <= 1'b0;
      delayCnt_q    <= '0;
    end else if (wrCtrl) begin
      autoRestart_q <= req.writedata[`PWSD_RESTART_BIT];
      delayCnt_q    <= req.writedata[DELAY_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // restart gating
  // ----------------------------------------------------------------------
  // next period start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      running_q <= 1'b0;
    end else if (evtFlag_q || condition || wrEvt1) begin
      running_q <= 1'b0;
    end else if (pwmPeriodStart) begin
      running_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // dead-band step divider
  // ----------------------------------------------------------------------
  // four-tosc step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stepCnt_q <= 2'h0;
    end else if (stepCnt_q == 2'(`PWSD_STEP_CYC - 1)) begin
      stepCnt_q <= 2'h0;
    end else begin
      stepCnt_q <= stepCnt_q + 2'h1;
    end
  end
  assign stepEn = stepCnt_q == 2'(`PWSD_STEP_CYC - 1);

  pwsd_deadband #(.DW(DELAY_W)) u_dbA (
    .clk        (clk),
    .reset      (reset),
    .stepEn     (stepEn),
    .delayCount (delayCnt_q),
    .rawIn      (pwmRawA),
    .delayedOut (dbA)
  );

  pwsd_deadband #(.DW(DELAY_W)) u_dbB (
    .clk        (clk),
    .reset      (reset),
    .stepEn     (stepEn),
    .delayCount (delayCnt_q),
    .rawIn      (~pwmRawA),
    .delayedOut (dbB)
  );

  // ----------------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------------
  // shutdown takes effect on the next edge from the live condition, so
  // the one-flop output rule costs a single cycle, not a flag round trip
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwmOutputA   <= 1'b0;
      pwmOutputAOe <= 1'b0;
      pwmOutputB   <= 1'b0;
      pwmOutputBOe <= 1'b0;
    end else if (running_q && !condition && !evtFlag_q && !wrEvt1) begin
      pwmOutputA   <= dbA;
      pwmOutputAOe <= 1'b1;
      pwmOutputB   <= dbB;
      pwmOutputBOe <= 1'b1;
    end else begin
      pwmOutputA   <= stateA_q == 2'h1;
      pwmOutputAOe <= ~stateA_q[1];
      pwmOutputB   <= stateB_q == 2'h1;
      pwmOutputBOe <= ~stateB_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // interrupts: bit 0 shutdown entered, bit 1 shutdown released
  // ----------------------------------------------------------------------
  logic evtPrev_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evtPrev_q <= 1'b0;
    end else begin
      evtPrev_q <= evtFlag_q;
    end
  end
  assign evtRise = evtFlag_q & ~evtPrev_q;
  assign evtFall = ~evtFlag_q & evtPrev_q;

  // set wins over a clear landing in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqStat_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? evtRise : evtFall) begin
          irqStat_q[i] <= 1'b1;
        end else if (busState_q == pwsd_pkg::PWSD_ANSWER && req.write &&
                     req.address == `PWSD_OFS_IRQSTAT &&
                     req.writedata[i]) begin
          irqStat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqEn_q <= 2'h0;
    end else if (busState_q == pwsd_pkg::PWSD_ANSWER && req.write &&
                 req.address == `PWSD_OFS_IRQEN) begin
      irqEn_q <= req.writedata[1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_q & irqEn_q);
    end
  end

  // ----------------------------------------------------------------------
  // avalon-mm slave: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busState_q <= pwsd_pkg::PWSD_IDLE;
    end else begin
      case (busState_q)
        pwsd_pkg::PWSD_IDLE: begin
          if (req.read || req.write) begin
            busState_q <= pwsd_pkg::PWSD_ANSWER;
          end
        end
        default: begin
          busState_q <= pwsd_pkg::PWSD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avsWaitrequest <= 1'b1;
    end else begin
      avsWaitrequest <= !(busState_q == pwsd_pkg::PWSD_IDLE &&
                          (req.read || req.write));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avsReaddata <= 32'h0;
    end else if (busState_q == pwsd_pkg::PWSD_IDLE && req.read) begin
      if (req.address == `PWSD_OFS_SHUTDOWN) begin
        avsReaddata <= {24'h0, evtFlag_q, srcSel_q, stateA_q, stateB_q};
      end else if (req.address == `PWSD_OFS_PWMCTRL) begin
        avsReaddata <= {24'h0, autoRestart_q, 7'(delayCnt_q)};
      end else if (req.address == `PWSD_OFS_IRQSTAT) begin
        avsReaddata <= {30'h0, irqStat_q};
      end else if (req.address == `PWSD_OFS_IRQEN) begin
        avsReaddata <= {30'h0, irqEn_q};
      end else begin
        avsReaddata <= 32'h0;
      end
    end
  end

endmodule : pwsd_top

// ---- verif/pwsd_top_sva.sv ----
/* port checker for pwsd_top, bound to it at the foot.
   assumes one clock and register writes that land at the answering edge. */
`timescale 1ns/10ps
module pwsd_top_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register bus
  input wire logic [3:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [31:0] avsReaddata,
  input wire logic        avsWaitrequest,
  // pins
  input wire logic        pwmRawA,
  input wire logic        eventPin_n,
  input wire logic        comparatorOut,
  input wire logic        pwmOutputA,
  input wire logic        pwmOutputAOe,
  input wire logic        pwmOutputB,
  input wire logic        pwmOutputBOe
);
  // ---
  // shadow of written fields
  // ---
  logic [6:0] sdQ;
  logic [6:0] dlyQ;
  logic [9:0] hiQ;
  logic       cnd;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdQ  <= 7'h00;
      dlyQ <= 7'h00;
    end else if (avsWrite && !avsWaitrequest) begin
      if (avsAddress == 4'h0) sdQ <= avsWritedata[6:0];
      if (avsAddress == 4'h4) dlyQ <= avsWritedata[6:0];
    end
  end
  // run length of raw high bounds the earliest delayed rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) hiQ <= 10'h000;
    else if (!pwmRawA) hiQ <= 10'h000;
    else if (hiQ != 10'h3ff) hiQ <= hiQ + 10'h001;
  end
  assign cnd = (sdQ[4] & comparatorOut) | (sdQ[6] & !eventPin_n);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ---
  // properties
  // ---
  property p_waitOne;
    !avsWaitrequest |=> avsWaitrequest;
  endproperty
  a_waitOne: assert property (p_waitOne) else $error("wait low twice");
  property p_waitAns;
    (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest;
  endproperty
  a_waitAns: assert property (p_waitAns) else $error("no answer");
  property p_idle;
    !(avsRead || avsWrite) && avsWaitrequest |=> avsWaitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("answer unasked");
  property p_rdHi;
    avsRead && !avsWaitrequest |-> avsReaddata[31:8] == 24'h0;
  endproperty
  a_rdHi: assert property (p_rdHi) else $error("upper read bits set");
  property p_sdA;
    cnd ##1 (cnd && $stable(sdQ)) |-> (sdQ[3] ? !pwmOutputAOe :
      (pwmOutputAOe && pwmOutputA == sdQ[2]));
  endproperty
  a_sdA: assert property (p_sdA) else $error("a not in shutdown");
  property p_sdB;
    cnd ##1 (cnd && $stable(sdQ)) |-> (sdQ[1] ? !pwmOutputBOe :
      (pwmOutputBOe && pwmOutputB == sdQ[0]));
  endproperty
  a_sdB: assert property (p_sdB) else $error("b not in shutdown");
  property p_fallA;
    $fell(pwmRawA) && sdQ[3:2] == 2'b00 |-> ##2 !pwmOutputA;
  endproperty
  a_fallA: assert property (p_fallA) else $error("a fall late");
  property p_fallB;
    $rose(pwmRawA) && sdQ[1:0] == 2'b00 |-> ##2 !pwmOutputB;
  endproperty
  a_fallB: assert property (p_fallB) else $error("b fall late");
  property p_rise;
    $rose(pwmOutputA) && sdQ[3:2] == 2'b00 |-> hiQ >= {1'b0, dlyQ, 2'b00};
  endproperty
  a_rise: assert property (p_rise) else $error("a rise early");
endmodule : pwsd_top_sva

bind pwsd_top pwsd_top_sva pwsd_top_sva_inst (
  .clk,
  .reset,
  .avsAddress,
  .avsRead,
  .avsWrite,
  .avsWritedata,
  .avsReaddata,
  .avsWaitrequest,
  .pwmRawA,
  .eventPin_n,
  .comparatorOut,
  .pwmOutputA,
  .pwmOutputAOe,
  .pwmOutputB,
  .pwmOutputBOe
);

// ---- verif/pwsd_bridge.sv ----
/* power switches and shutdown sources facing the block.
   assumes the bench raises trips just after a clock edge. */
`timescale 1ns/10ps
module pwsd_bridge (
  // pin drive from the block
  input  wire pwsd_pkg::pwsd_pin_s pinA,
  input  wire pwsd_pkg::pwsd_pin_s pinB,
  // trips from the bench
  input  wire logic                tripPin,
  input  wire logic                tripComp,
  // shutdown sources
  output      logic                eventPin_n,
  output      logic                comparatorOut,
  // switch gates
  output      logic                gateA,
  output      logic                gateB
);
  assign eventPin_n    = !tripPin;
  assign comparatorOut = tripComp;
  // pull-downs keep a released switch off
  assign gateA = pinA.oe ? pinA.out : 1'b0;
  assign gateB = pinB.oe ? pinB.out : 1'b0;
endmodule : pwsd_bridge

// ---- verif/pwsd_top_tb.sv ----
/* self-checking bench for pwsd_top with its switch model.
   assumes the checker is bound to the design elsewhere. */
`timescale 1ns/10ps
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module pwsd_top_tb;
  logic                clk;
  logic                reset;
  logic [3:0]          avsAddress;
  logic                avsRead;
  logic                avsWrite;
  logic [31:0]         avsWritedata;
  logic [31:0]         avsReaddata;
  logic                avsWaitrequest;
  logic                raw;
  logic                pst;
  logic                tripPin;
  logic                tripComp;
  logic                eventPin_n;
  logic                comparatorOut;
  logic                outA;
  logic                oeA;
  logic                outB;
  logic                oeB;
  logic                irq;
  logic                gateA;
  logic                gateB;
  logic                c;
  logic [31:0]         q;
  logic [31:0]         f;
  logic [31:0]         d;
  int                  na;
  int                  nb;
  int                  ph;
  int                  cyc;
  int                  mismatches;
  int                  comparisons;
  pwsd_pkg::pwsd_pin_s pinA;
  pwsd_pkg::pwsd_pin_s pinB;
  assign pinA = {outA, oeA};
  assign pinB = {outB, oeB};
  pwsd_top pwsd_top_inst (
    .clk,
    .reset,
    .avsAddress,
    .avsRead,
    .avsWrite,
    .avsWritedata,
    .avsReaddata,
    .avsWaitrequest,
    .pwmRawA(raw),
    .pwmPeriodStart(pst),
    .eventPin_n,
    .comparatorOut,
    .pwmOutputA(outA),
    .pwmOutputAOe(oeA),
    .pwmOutputB(outB),
    .pwmOutputBOe(oeB),
    .irq
  );
  pwsd_bridge pwsd_bridge_inst (
    .pinA,
    .pinB,
    .tripPin,
    .tripComp,
    .eventPin_n,
    .comparatorOut,
    .gateA,
    .gateB
  );
  always #5 clk = !clk;
  // edges since reset release; the design's step divider starts there too
  always @(posedge clk) cyc <= reset ? 0 : cyc + 1;
  // ---
  // helpers
  // ---
  function automatic logic cond_f(logic [2:0] s, logic pl, logic cm);
    return (s[0] & cm) | (s[2] & pl);
  endfunction : cond_f
  function automatic logic [1:0] sd_f(logic [1:0] st);
    return {!st[1], !st[1] & st[0]};
  endfunction : sd_f
  // steps run free, so the first step lands one to four cycles after the
  // raw edge; ph is the edge count mod 4 at the edge that sees the rise
  function automatic int rise_f(int dly, int ph);
    return (dly == 0) ? 2 : 4 * dly + 3 - ph;
  endfunction : rise_f
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] dt);
    int n;
    n = 0;
    avsAddress   <= a;
    avsWritedata <= dt;
    avsWrite     <= w;
    avsRead      <= !w;
    @(posedge clk);
    while (avsWaitrequest !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      print_verdict();
    end
    q = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic period();
    pst <= 1'b1;
    tick(1);
    pst <= 1'b0;
    tick(20);
  endtask : period
  task automatic meas(input logic v, output int ea, output int eb,
                      output int p);
    ea = 0;
    eb = 0;
    p  = 0;
    raw <= v;
    for (int k = 1; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (k == 1) p = cyc % 4;
      `CHK(gateA & gateB, 1'b0)
      if (ea == 0 && gateA === v) ea = k;
      if (eb == 0 && gateB === !v) eb = k;
    end
    @(posedge clk);
  endtask : meas
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // ---
  // tests
  // ---
  initial begin
    clk = 0; reset = 1; avsAddress = 0; avsRead = 0; avsWrite = 0;
    avsWritedata = 0; raw = 0; pst = 0; tripPin = 0; tripComp = 0;
    mismatches = 0; comparisons = 0;
    void'($urandom(34312));
    tick(3);
    reset <= 1'b0;
    tick(1);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 4'h2, 32'hff);
    bus(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    f = {24'h0, 8'($urandom) & 8'h2f};
    bus(1'b1, 4'h0, f);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, f)
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 0 : $urandom_range(4, 1);
      bus(1'b1, 4'h4, d);
      bus(1'b1, 4'h0, 32'h0);
      period();
      meas(1'b1, na, nb, ph);
      `CHK(na, rise_f(d, ph))
      `CHK(nb, 2)
      meas(1'b0, na, nb, ph);
      `CHK(na, 2)
      `CHK(nb, rise_f(d, ph))
    end
    $display("test dead-band done");
    for (int i = 0; i < 16; i++) begin
      f = {25'h0, 3'(i), 4'($urandom)};
      c = cond_f(3'(i), i[3], !i[3]);
      bus(1'b1, 4'h0, f);
      tripPin  <= i[3];
      tripComp <= !i[3];
      tick(3);
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q[7], c)
      if (c) begin
        `CHK({pinA.oe, gateA}, sd_f(f[3:2]))
        `CHK({pinB.oe, gateB}, sd_f(f[1:0]))
        bus(1'b1, 4'h0, f);
        bus(1'b0, 4'h0, 32'h0);
        `CHK(q[7], 1'b1)
      end
      tripPin  <= 1'b0;
      tripComp <= 1'b0;
      tick(3);
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q[7], c)
      bus(1'b1, 4'h0, f);
      if (c) `CHK({pinB.oe, gateB}, sd_f(f[1:0]))
      period();
      `CHK({pinB.oe, gateB}, 2'b11)
    end
    $display("test shutdown sources done");
    bus(1'b1, 4'h4, 32'h80);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q[7:0], 8'h80)
    bus(1'b1, 4'h0, 32'h40);
    tripPin <= 1'b1;
    tick(8);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q[7], 1'b1)
    tripPin <= 1'b0;
    tick(3);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q[7], 1'b0)
    period();
    `CHK({pinB.oe, gateB}, 2'b11)
    $display("test auto-restart done");
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'h3);
    bus(1'b1, 4'hc, 32'h1);
    tick(2);
    `CHK(irq, 1'b0)
    bus(1'b1, 4'h0, 32'h80);
    tick(2);
    `CHK(irq, 1'b1)
    `CHK({pinA.oe, gateA}, 2'b10)
    bus(1'b1, 4'h8, 32'h3);
    tick(2);
    `CHK(irq, 1'b0)
    bus(1'b1, 4'hc, 32'h0);
    bus(1'b1, 4'h0, 32'h0);
    tick(2);
    `CHK(irq, 1'b0)
    bus(1'b0, 4'h8, 32'h0);
    `CHK(q[1:0], 2'b10)
    bus(1'b1, 4'hc, 32'h2);
    tick(2);
    `CHK(irq, 1'b1)
    bus(1'b1, 4'h8, 32'h2);
    tick(2);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    print_verdict();
  end
  // a hang ends the run as a mismatch
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule : pwsd_top_tb
